// *** verilog/aos_pkg.sv ***
// Package for the analogue output scaler: modes, limits, fault levels, timing
package aos_pkg;

   // ****************************************
   // Encodings
   // ****************************************
   typedef enum logic [1:0] {AOS_ACT_CUR, AOS_PAS_CUR, AOS_ACT_VOLT} aos_variant_t;
   typedef enum logic [2:0] {AOS_OFF, AOS_0_20, AOS_4_20, AOS_0_5, AOS_1_5, AOS_0_10, AOS_2_10, AOS_BUS} aos_mode_t;
   typedef enum logic [3:0] {AOS_KEEP, AOS_F_22_1, AOS_F_3_4, AOS_F_0_MA, AOS_F_11_V, AOS_F_5_5, AOS_F_1_2,
      AOS_F_0_6, AOS_F_0_V} aos_fault_t;

   // ****************************************
   // Levels, in uA for current and mV for voltage
   // ****************************************
   localparam int OUT_W = 16;
   localparam logic [15:0] LVL_0 = 16'h0000;
   localparam logic [15:0] LVL_1_V = 16'h03e8;
   localparam logic [15:0] LVL_2_V = 16'h07d0;
   localparam logic [15:0] LVL_4_MA = 16'h0fa0;
   localparam logic [15:0] LVL_5_V = 16'h1388;
   localparam logic [15:0] LVL_10_V = 16'h2710;
   localparam logic [15:0] LVL_20_MA = 16'h4e20;
   localparam logic [15:0] LVL_22_1_MA = 16'h5654;
   localparam logic [15:0] LVL_3_4_MA = 16'h0d48;
   localparam logic [15:0] LVL_11_V = 16'h2af8;
   localparam logic [15:0] LVL_5_5_V = 16'h157c;
   localparam logic [15:0] LVL_1_2_V = 16'h04b0;
   localparam logic [15:0] LVL_0_6_V = 16'h0258;

   // ****************************************
   // Range extensions, in 0.1 % steps
   // ****************************************
   localparam logic [9:0] EXT_LO_MAX_ACT = 10'h3e7;
   localparam logic [9:0] EXT_LO_MAX_PAS = 10'h12b;
   localparam logic [9:0] EXT_HI_MAX_CUR = 10'h0c7;
   localparam logic [9:0] EXT_HI_MAX_VOLT = 10'h063;
   localparam int EXT_SCALE = 1000;

   // ****************************************
   // Frame gap timing
   // ****************************************
   localparam int CLK_PERIOD_NS = 8;
   localparam int GAP_UNIT_NS = 1000000000;
   localparam int GAP_UNIT_CYCLES = GAP_UNIT_NS / CLK_PERIOD_NS;
   localparam logic [6:0] GAP_MAX_S = 7'h63;

   // ****************************************
   // Carriers
   // ****************************************
   typedef struct packed {
      aos_variant_t variant;
      aos_mode_t mode;
      aos_fault_t fault_output_action;
      logic output_source_select;
      logic signed [15:0] output_low_input_point;
      logic signed [15:0] output_high_input_point;
      logic [9:0] lower_range_extension;
      logic [9:0] upper_range_extension;
      logic [6:0] frame_gap_timeout;
   } aos_cfg_t;

   typedef struct packed {
      logic valid;
      logic bus;
      logic [15:0] lower;
      logic [15:0] upper;
   } aos_limits_t;

endpackage : aos_pkg

// *** verilog/aos_scaler.sv ***
// Analogue output scaler: ranged scaling, clamping, fault levels and bus control
`timescale 1ns/1ps
// Overview of operation
// - Active current version offers off, 0-20 mA, 4-20 mA and bus modes.
// - Passive current version offers only off, 4-20 mA and bus modes.
// - Voltage version offers off, 0-5, 1-5, 0-10, 2-10 V and bus modes.
// - Bus mode drives the output from the value written over the serial link.
// - Ranged output is (value-low)/(high-low) times (upper-lower) plus lower limit.
// - Upper limit 20 mA, 5 V or 10 V; lower limit per selected mode.
// - Low input point above high point gives a falling characteristic.
// - Output beyond the extended range saturates at the nearer border.
// - Lower border is lower limit less its percentage; capped 99.9 or 29.9 %.
// - Upper border is upper limit plus its percentage; capped 19.9 or 9.9 %.
// - Current versions on fault keep level or force 22.1 or 3.4 mA; only the active current version can force 0 mA.
// - Voltage version on fault keeps level or forces 11, 5.5, 1.2, 0.6, 0 V.
// - When the fault clears the output returns to the scaled value, or to the written value in bus mode.
// - Source select picks live displayed value or held peak value.
// - Frame gap reaching the timeout faults bus outputs; zero disables the check.
// - Input outside its permissible window raises under or over range flags.
module aos_scaler
   import aos_pkg::*;
#(
   parameter int SEC_CYCLES = GAP_UNIT_CYCLES
) (
   // Clock and reset
   input wire logic clock,
   input wire logic reset,
   // Configuration
   input wire aos_cfg_t cfg,
   // Measurement side
   input wire logic signed [15:0] displayed_value,
   input wire logic signed [15:0] peak_value,
   input wire logic signed [15:0] input_level,
   input wire logic signed [15:0] input_window_low,
   input wire logic signed [15:0] input_window_high,
   // Serial register path
   input wire logic bus_write,
   input wire logic [15:0] bus_value,
   input wire logic frame_received,
   // Loop side and status
   output logic [15:0] drive_code,
   output logic under_range,
   output logic over_range,
   output logic gap_expired,
   output logic fault_active
);

   localparam int NUM_W = 34;
   localparam int DEN_W = 17;
   localparam int TICK_W = $clog2(SEC_CYCLES);

   generate
      if (SEC_CYCLES < 2) begin : g_bad_sec
         $error("SEC_CYCLES must be at least 2");
      end
   endgenerate

   // ****************************************
   // Decode functions
   // ****************************************
   function automatic aos_limits_t mode_limits(input aos_variant_t v, input aos_mode_t m);
      aos_limits_t l;
      l = '{valid: 1'b0, bus: 1'b0, lower: LVL_0, upper: LVL_0};
      unique case (m)
         AOS_0_20: l = '{valid: v == AOS_ACT_CUR, bus: 1'b0, lower: LVL_0, upper: LVL_20_MA};
         AOS_4_20: l = '{valid: v != AOS_ACT_VOLT, bus: 1'b0, lower: LVL_4_MA, upper: LVL_20_MA};
         AOS_0_5: l = '{valid: v == AOS_ACT_VOLT, bus: 1'b0, lower: LVL_0, upper: LVL_5_V};
         AOS_1_5: l = '{valid: v == AOS_ACT_VOLT, bus: 1'b0, lower: LVL_1_V, upper: LVL_5_V};
         AOS_0_10: l = '{valid: v == AOS_ACT_VOLT, bus: 1'b0, lower: LVL_0, upper: LVL_10_V};
         AOS_2_10: l = '{valid: v == AOS_ACT_VOLT, bus: 1'b0, lower: LVL_2_V, upper: LVL_10_V};
         AOS_BUS: l = '{valid: 1'b1, bus: 1'b1, lower: LVL_0, upper: LVL_0};
         default: l = '{valid: 1'b0, bus: 1'b0, lower: LVL_0, upper: LVL_0};
      endcase
      if (v != AOS_ACT_CUR && v != AOS_PAS_CUR && v != AOS_ACT_VOLT) begin
         l.valid = 1'b0;
      end
      return l;
   endfunction : mode_limits

   // Returns {forced, level}; unsupported choices fall back to keeping the level
   function automatic logic [16:0] fault_level(input aos_variant_t v, input aos_fault_t a);
      logic cur;
      cur = (v != AOS_ACT_VOLT);
      unique case (a)
         AOS_F_22_1: return {cur, LVL_22_1_MA};
         AOS_F_3_4: return {cur, LVL_3_4_MA};
         AOS_F_0_MA: return {v == AOS_ACT_CUR, LVL_0};
         AOS_F_11_V: return {!cur, LVL_11_V};
         AOS_F_5_5: return {!cur, LVL_5_5_V};
         AOS_F_1_2: return {!cur, LVL_1_2_V};
         AOS_F_0_6: return {!cur, LVL_0_6_V};
         AOS_F_0_V: return {!cur, LVL_0};
         default: return {1'b0, LVL_0};
      endcase
   endfunction : fault_level

   function automatic logic [9:0] cap_ext(input logic [9:0] e, input logic [9:0] lim);
      return (e > lim) ? lim : e;
   endfunction : cap_ext

   // ****************************************
   // Mode, borders and source
   // ****************************************
   aos_limits_t lim;
   logic [9:0] lo_ext;
   logic [9:0] hi_ext;
   logic [31:0] lo_border;
   logic [31:0] hi_border;
   logic signed [15:0] src_value;
   logic [16:0] fault_sel;

   always_comb begin
      lim = mode_limits(cfg.variant, cfg.mode);
      lo_ext = cap_ext(cfg.lower_range_extension,
         (cfg.variant == AOS_PAS_CUR) ? EXT_LO_MAX_PAS : EXT_LO_MAX_ACT);
      hi_ext = cap_ext(cfg.upper_range_extension,
         (cfg.variant == AOS_ACT_VOLT) ? EXT_HI_MAX_VOLT : EXT_HI_MAX_CUR);
      lo_border = 32'(lim.lower) - (32'(lim.lower) * 32'(lo_ext)) / 32'(EXT_SCALE);
      hi_border = 32'(lim.upper) + (32'(lim.upper) * 32'(hi_ext)) / 32'(EXT_SCALE);
      src_value = cfg.output_source_select ? peak_value : displayed_value;
      fault_sel = fault_level(cfg.variant, cfg.fault_output_action);
   end

   // ****************************************
   // Sequential divider for the scaling formula
   // ****************************************
   typedef enum logic [1:0] {ST_LOAD, ST_DIV, ST_DONE} aos_state_t;
   aos_state_t state_q, state_d;
   logic [NUM_W-1:0] quo_q, quo_d;
   logic [DEN_W:0] rem_q, rem_d;
   logic [DEN_W-1:0] den_q, den_d;
   logic neg_q, neg_d;
   logic [5:0] cnt_q, cnt_d;
   logic [15:0] base_q, base_d;
   logic [15:0] result_q, result_d;
   logic signed [DEN_W-1:0] num_diff;
   logic signed [DEN_W-1:0] den_diff;
   logic signed [NUM_W-1:0] num_full;
   logic [DEN_W:0] rem_try;
   logic signed [NUM_W+1:0] scaled;

   always_comb begin
      num_diff = DEN_W'(src_value) - DEN_W'(cfg.output_low_input_point);
      den_diff = DEN_W'(cfg.output_high_input_point) - DEN_W'(cfg.output_low_input_point);
      num_full = NUM_W'(num_diff) * NUM_W'($signed({1'b0, lim.upper - lim.lower}));
      state_d = state_q;
      quo_d = quo_q;
      rem_d = rem_q;
      den_d = den_q;
      neg_d = neg_q;
      cnt_d = cnt_q;
      base_d = base_q;
      result_d = result_q;
      rem_try = {rem_q[DEN_W-1:0], quo_q[NUM_W-1]};
      scaled = '0;
      unique case (state_q)
         ST_LOAD: begin
            quo_d = num_full[NUM_W-1] ? NUM_W'(-num_full) : NUM_W'(num_full);
            den_d = den_diff[DEN_W-1] ? DEN_W'(-den_diff) : DEN_W'(den_diff);
            neg_d = num_full[NUM_W-1] ^ den_diff[DEN_W-1];
            rem_d = '0;
            cnt_d = '0;
            base_d = lim.lower;
            if (den_diff == '0) begin
               quo_d = '0;
               state_d = ST_DONE;
            end else begin
               state_d = ST_DIV;
            end
         end
         ST_DIV: begin
            if (rem_try >= {1'b0, den_q}) begin
               rem_d = rem_try - {1'b0, den_q};
               quo_d = {quo_q[NUM_W-2:0], 1'b1};
            end else begin
               rem_d = rem_try;
               quo_d = {quo_q[NUM_W-2:0], 1'b0};
            end
            cnt_d = cnt_q + 6'h01;
            if (cnt_q == 6'(NUM_W - 1)) begin
               state_d = ST_DONE;
            end
         end
         ST_DONE: begin
            scaled = (neg_q ? -$signed({2'b00, quo_q}) : $signed({2'b00, quo_q})) + (NUM_W+2)'(base_q);
            if (scaled < $signed((NUM_W+2)'(lo_border))) begin
               result_d = lo_border[15:0];
            end else if (scaled > $signed((NUM_W+2)'(hi_border))) begin
               result_d = hi_border[15:0];
            end else begin
               result_d = scaled[15:0];
            end
            state_d = ST_LOAD;
         end
      endcase
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         state_q <= ST_LOAD;
         quo_q <= '0;
         rem_q <= '0;
         den_q <= '0;
         neg_q <= 1'b0;
         cnt_q <= '0;
         base_q <= '0;
         result_q <= '0;
      end else begin
         state_q <= state_d;
         quo_q <= quo_d;
         rem_q <= rem_d;
         den_q <= den_d;
         neg_q <= neg_d;
         cnt_q <= cnt_d;
         base_q <= base_d;
         result_q <= result_d;
      end
   end

   // ****************************************
   // Frame gap watchdog and input window
   // ****************************************
   logic [TICK_W-1:0] tick_q, tick_d;
   logic [6:0] secs_q, secs_d;
   logic gap_q, gap_d;
   logic under_q, under_d;
   logic over_q, over_d;
   logic [15:0] bus_q, bus_d;
   logic gap_hit;

   always_comb begin
      tick_d = tick_q;
      secs_d = secs_q;
      if (frame_received) begin
         tick_d = '0;
         secs_d = '0;
      end else if (tick_q == TICK_W'(SEC_CYCLES - 1)) begin
         tick_d = '0;
         if (secs_q != GAP_MAX_S) begin
            secs_d = secs_q + 7'h01;
         end
      end else begin
         tick_d = tick_q + TICK_W'(1);
      end
      // Next count, so a frame that restarts the timer can clear the flag
      gap_hit = (cfg.frame_gap_timeout != 7'h00) && (secs_d >= cfg.frame_gap_timeout);
      gap_d = gap_hit ? 1'b1 : (frame_received ? 1'b0 : gap_q);
      under_d = input_level < input_window_low;
      over_d = input_level > input_window_high;
      bus_d = bus_write ? bus_value : bus_q;
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         tick_q <= '0;
         secs_q <= '0;
         gap_q <= 1'b0;
         under_q <= 1'b0;
         over_q <= 1'b0;
         bus_q <= '0;
      end else begin
         tick_q <= tick_d;
         secs_q <= secs_d;
         gap_q <= gap_d;
         under_q <= under_d;
         over_q <= over_d;
         bus_q <= bus_d;
      end
   end

   // ****************************************
   // Output selection
   // ****************************************
   logic [15:0] drive_q, drive_d;
   logic fault_q, fault_d;

   always_comb begin
      fault_d = 1'b0;
      drive_d = drive_q;
      if (!lim.valid || cfg.mode == AOS_OFF) begin
         drive_d = LVL_0;
      end else begin
         fault_d = lim.bus ? gap_q : (under_q || over_q);
         if (fault_d) begin
            if (fault_sel[16]) begin
               drive_d = fault_sel[15:0];
            end
         end else begin
            drive_d = lim.bus ? bus_q : result_q;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         drive_q <= '0;
         fault_q <= 1'b0;
      end else begin
         drive_q <= drive_d;
         fault_q <= fault_d;
      end
   end

   assign drive_code = drive_q;
   assign under_range = under_q;
   assign over_range = over_q;
   assign gap_expired = gap_q;
   assign fault_active = fault_q;

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);

   chk_off_zero: assert property (cfg.mode == AOS_OFF |=> drive_code == LVL_0)
      else $error("drive not zero in disabled mode");
   chk_bus_follow: assert property (lim.bus && lim.valid && !fault_d |=> drive_code == $past(bus_q))
      else $error("bus mode output does not follow written value");
   chk_clamp_range: assert property (state_q == ST_DONE
      |=> result_q >= $past(lo_border[15:0]) && result_q <= $past(hi_border[15:0]))
      else $error("ranged result outside extended range");
   chk_fault_force: assert property (lim.valid && fault_d && fault_sel[16] |=> drive_code == $past(fault_sel[15:0]))
      else $error("fault level not applied");
   chk_fault_keep: assert property (lim.valid && fault_d && !fault_sel[16] |=> $stable(drive_code))
      else $error("keep action changed the output");
   chk_gap_off: assert property (cfg.frame_gap_timeout == 7'h00 && frame_received |=> !gap_expired)
      else $error("gap flagged with watchdog disabled");
   chk_under_flag: assert property (input_level < input_window_low |=> under_range)
      else $error("under range not flagged");
   chk_div_done: assert property (state_q == ST_LOAD |-> ##[1:36] state_q == ST_DONE)
      else $error("scaling division did not finish in time");
   chk_ext_cap: assert property (cfg.variant == AOS_PAS_CUR |-> lo_ext <= EXT_LO_MAX_PAS)
      else $error("lower extension above passive limit");

   cov_ranged: cover property (lim.valid && !lim.bus && !fault_d ##1 state_q == ST_DONE);
   cov_fault_exit: cover property (fault_q ##1 !fault_q && lim.valid);
   cov_gap_expire: cover property ($rose(gap_expired) && cfg.mode == AOS_BUS);

endmodule : aos_scaler

// *** sim/aos_loop_rx.sv ***
// Behavioural model of the current loop or voltage input receiver
`timescale 1ns/1ps
module aos_loop_rx
   import aos_pkg::*;
(
   // Clock and reset
   input wire logic clock,
   input wire logic reset,
   // Loop side
   input wire logic [15:0] drive_code,
   input wire aos_variant_t variant,
   // Sensed level
   output logic [15:0] sensed_q,
   output logic loop_dead
);
   logic [15:0] sensed_d;

   // ****************************************
   // Receiver settles one cycle after the drive
   // ****************************************
   always_comb begin
      sensed_d = drive_code;
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         sensed_q <= 16'h0000;
      end else begin
         sensed_q <= sensed_d;
      end
   end

   // Zero current on a current version reads as a broken loop
   assign loop_dead = (variant != AOS_ACT_VOLT) && (sensed_q == 16'h0000);
endmodule : aos_loop_rx

// *** sim/aos_scaler_tb.sv ***
// Self-checking testbench of the analogue output scaler
`timescale 1ns/1ps
module aos_scaler_tb
   import aos_pkg::*;
;
   typedef struct {aos_variant_t v; aos_mode_t m; logic signed [15:0] lo, hi, val; logic [9:0] le, he;
      logic [15:0] exp;} aos_case_t;
   typedef struct {aos_variant_t v; aos_mode_t m; aos_fault_t a; logic [15:0] exp; logic [15:0] ok;} aos_flt_t;

   logic clock;
   logic reset;
   aos_cfg_t cfg;
   logic signed [15:0] displayed_value, peak_value, input_level, input_window_low, input_window_high;
   logic bus_write, frame_received;
   logic [15:0] bus_value, drive_code, sensed_q;
   logic under_range, over_range, gap_expired, fault_active, loop_dead;
   int err_count = 0;
   int checks_done = 0;
   int cycle_count = 0;
   aos_case_t cases[16];
   aos_flt_t flts[10];

   aos_scaler #(.SEC_CYCLES(16)) u_aos_scaler (.clock(clock), .reset(reset), .cfg(cfg),
      .displayed_value(displayed_value), .peak_value(peak_value), .input_level(input_level),
      .input_window_low(input_window_low), .input_window_high(input_window_high), .bus_write(bus_write),
      .bus_value(bus_value), .frame_received(frame_received), .drive_code(drive_code),
      .under_range(under_range), .over_range(over_range), .gap_expired(gap_expired),
      .fault_active(fault_active));

   aos_loop_rx u_aos_loop_rx (.clock(clock), .reset(reset), .drive_code(drive_code), .variant(cfg.variant),
      .sensed_q(sensed_q), .loop_dead(loop_dead));

   // ****************************************
   // Clock, timeout and verdict
   // ****************************************
   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end

   task automatic stop_test();
      if (err_count == 0 && checks_done > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : stop_test

   always @(posedge clock) begin
      cycle_count++;
      if (cycle_count == 20000) begin
         err_count++;
         stop_test();
      end
   end

   // ****************************************
   // Access tasks
   // ****************************************
   task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_count++;
         $display("unexpected %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic settle(int n);
      repeat (n) @(posedge clock);
      #1;
   endtask : settle

   task automatic set_range(aos_case_t c);
      @(posedge clock);
      cfg.variant <= c.v;
      cfg.mode <= c.m;
      cfg.output_low_input_point <= c.lo;
      cfg.output_high_input_point <= c.hi;
      cfg.lower_range_extension <= c.le;
      cfg.upper_range_extension <= c.he;
      displayed_value <= c.val;
      settle(80);
   endtask : set_range

   task automatic set_input(logic signed [15:0] lvl, int n);
      @(posedge clock);
      input_level <= lvl;
      settle(n);
   endtask : set_input

   task automatic bus_wr(logic [15:0] v);
      @(posedge clock);
      bus_write <= 1'b1;
      bus_value <= v;
      @(posedge clock);
      bus_write <= 1'b0;
      settle(2);
   endtask : bus_wr

   task automatic frame();
      @(posedge clock);
      frame_received <= 1'b1;
      @(posedge clock);
      frame_received <= 1'b0;
   endtask : frame

   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      cases = '{'{AOS_ACT_CUR, AOS_4_20, 0, 1000, 500, 0, 0, 16'h2ee0},
         '{AOS_ACT_CUR, AOS_0_20, 0, 1000, 250, 0, 0, 16'h1388},
         '{AOS_ACT_CUR, AOS_4_20, 1000, 0, 250, 0, 0, 16'h3e80},
         '{AOS_ACT_CUR, AOS_4_20, 0, 1000, 2000, 0, 100, 16'h55f0},
         '{AOS_ACT_CUR, AOS_4_20, 0, 1000, 2000, 0, 300, 16'h5dac},
         '{AOS_ACT_CUR, AOS_4_20, 0, 1000, -1000, 200, 0, 16'h0c80},
         '{AOS_PAS_CUR, AOS_4_20, 0, 1000, -1000, 500, 0, 16'h0af4},
         '{AOS_PAS_CUR, AOS_0_20, 0, 1000, 500, 0, 0, 16'h0000},
         '{AOS_ACT_VOLT, AOS_0_5, 0, 1000, 500, 0, 0, 16'h09c4},
         '{AOS_ACT_VOLT, AOS_1_5, 0, 1000, 500, 0, 0, 16'h0bb8},
         '{AOS_ACT_VOLT, AOS_0_10, 0, 1000, 500, 0, 0, 16'h1388},
         '{AOS_ACT_VOLT, AOS_2_10, 0, 1000, 500, 0, 0, 16'h1770},
         '{AOS_ACT_VOLT, AOS_4_20, 0, 1000, 500, 0, 0, 16'h0000},
         '{AOS_ACT_VOLT, AOS_2_10, 0, 1000, 2000, 0, 150, 16'h2aee},
         '{AOS_ACT_CUR, AOS_0_20, 0, 1000, -500, 999, 0, 16'h0000},
         '{AOS_ACT_CUR, AOS_4_20, 0, 1000, 333, 0, 0, 16'h2470}};
      flts = '{'{AOS_ACT_CUR, AOS_4_20, AOS_F_22_1, 16'h5654, 16'h2ee0},
         '{AOS_ACT_CUR, AOS_4_20, AOS_F_3_4, 16'h0d48, 16'h2ee0},
         '{AOS_ACT_CUR, AOS_4_20, AOS_F_0_MA, 16'h0000, 16'h2ee0},
         '{AOS_PAS_CUR, AOS_4_20, AOS_F_0_MA, 16'h2ee0, 16'h2ee0},
         '{AOS_ACT_VOLT, AOS_2_10, AOS_F_11_V, 16'h2af8, 16'h1770},
         '{AOS_ACT_VOLT, AOS_2_10, AOS_F_5_5, 16'h157c, 16'h1770},
         '{AOS_ACT_VOLT, AOS_2_10, AOS_F_1_2, 16'h04b0, 16'h1770},
         '{AOS_ACT_VOLT, AOS_2_10, AOS_F_0_6, 16'h0258, 16'h1770},
         '{AOS_ACT_VOLT, AOS_2_10, AOS_F_0_V, 16'h0000, 16'h1770},
         '{AOS_ACT_CUR, AOS_4_20, AOS_KEEP, 16'h2ee0, 16'h2ee0}};
      reset = 1'b1;
      cfg = '0;
      displayed_value = 16'sh0000;
      peak_value = 16'sh0000;
      input_level = 16'sh0000;
      input_window_low = -16'sh0064;
      input_window_high = 16'sh0064;
      bus_write = 1'b0;
      bus_value = 16'h0000;
      frame_received = 1'b0;
      repeat (3) @(posedge clock);
      reset <= 1'b0;
      settle(1);
      check("drive after reset", drive_code, 16'h0000);
      foreach (cases[i]) begin
         set_range(cases[i]);
         check("ranged drive", drive_code, cases[i].exp);
      end
      check("sensed level", sensed_q, 16'h2470);
      // Source selection between live and held value
      @(posedge clock);
      peak_value <= 16'sh02ee;
      cfg.output_source_select <= 1'b1;
      set_range(cases[1]);
      check("peak source", drive_code, 16'h3a98);
      @(posedge clock);
      cfg.output_source_select <= 1'b0;
      set_range(cases[1]);
      check("live source", drive_code, 16'h1388);
      // Fault levels, entry and release
      foreach (flts[i]) begin
         @(posedge clock);
         cfg.fault_output_action <= flts[i].a;
         set_range('{flts[i].v, flts[i].m, 0, 1000, 500, 0, 0, 16'h0000});
         set_input(16'sh00c8, 10);
         check("over flag", {15'h0000, over_range}, 16'h0001);
         check("fault flag", {15'h0000, fault_active}, 16'h0001);
         check("fault drive", drive_code, flts[i].exp);
         set_input(16'sh0000, 80);
         check("released drive", drive_code, flts[i].ok);
      end
      set_input(-16'sh00c8, 10);
      check("under flag", {15'h0000, under_range}, 16'h0001);
      set_range('{AOS_ACT_CUR, AOS_4_20, 0, 1000, 250, 0, 0, 16'h0000});
      check("kept level", drive_code, 16'h2ee0);
      set_input(16'sh0000, 80);
      check("after keep", drive_code, 16'h1f40);
      // Bus mode with frame gap watchdog
      @(posedge clock);
      cfg.mode <= AOS_BUS;
      cfg.fault_output_action <= AOS_F_22_1;
      cfg.frame_gap_timeout <= 7'h01;
      frame();
      bus_wr(16'h1234);
      check("bus drive", drive_code, 16'h1234);
      bus_wr(16'h0abc);
      set_input(16'sh00c8, 6);
      check("bus ignores window", drive_code, 16'h0abc);
      check("gap early", {15'h0000, gap_expired}, 16'h0000);
      settle(30);
      check("gap expired", {15'h0000, gap_expired}, 16'h0001);
      check("gap fault drive", drive_code, 16'h5654);
      frame();
      settle(2);
      check("gap cleared", {15'h0000, gap_expired}, 16'h0000);
      check("bus restored", drive_code, 16'h0abc);
      @(posedge clock);
      cfg.frame_gap_timeout <= 7'h00;
      frame();
      settle(60);
      check("gap disabled", {15'h0000, gap_expired}, 16'h0000);
      // Disabled mode output ignores bus writes and the gap watchdog
      @(posedge clock);
      cfg.mode <= AOS_OFF;
      cfg.frame_gap_timeout <= 7'h01;
      bus_wr(16'h4321);
      settle(40);
      check("off drive", drive_code, 16'h0000);
      check("loop dead", {15'h0000, loop_dead}, 16'h0001);
      stop_test();
   end
endmodule : aos_scaler_tb
